// ===== design/prfsd_pkg.sv
package prfsd_pkg;

    // Register offsets and reset value
    localparam logic [7:0] ADDR_REF_DIV_LO = 8'h11;
    localparam logic [7:0] ADDR_REF_DIV_HI = 8'h12;
    localparam logic [7:0] ADDR_PSC_CTRL = 8'h16;
    localparam logic [7:0] ADDR_OFFSET_CFG = 8'h18;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h19;
    localparam logic [7:0] ADDR_MON_SEL = 8'h1b;
    localparam logic [7:0] ADDR_REF_CTRL = 8'h1c;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Reference control fields
    localparam int REF_DIFF_EN = 0;
    localparam int REF_PRI_EN = 1;
    localparam int REF_SEC_EN = 2;
    localparam int REF_PIN_SEL_EN = 3;
    localparam int REF_MAN_SEC = 4;
    localparam int REF_AUTO_EN = 5;
    localparam int REF_PREFER_SEC = 6;
    localparam int REF_DEGLITCH_OFF = 7;

    // Offset and lock configuration fields
    localparam int OFS_XTAL_EN = 0;
    localparam int OFS_USE_STATUS = 1;
    localparam int OFS_SE_LOW_BIAS = 7;

    // Prescaler control fields and reference divider high-byte width
    localparam int PSC_MODE_LSB = 0;
    localparam int PSC_B_BYPASS = 3;
    localparam int PSC_RST_SHARED = 4;
    localparam int PSC_RST_AB = 5;
    localparam int PSC_RST_R = 6;
    localparam int REF_DIV_HI_BITS = 6;

    // Sync pin control field and codes
    localparam int SYNC_MODE_LSB = 6;
    localparam logic [1:0] SYNC_OFF = 2'h0;
    localparam logic [1:0] SYNC_ALL = 2'h1;
    localparam logic [1:0] SYNC_AB = 2'h2;
    localparam logic [1:0] SYNC_R = 2'h3;

    // Monitor pin source codes
    localparam logic [7:0] MON_PRI_BAD = 8'hf7;
    localparam logic [7:0] MON_SEC_BAD = 8'hf8;

    // Prescaler mode codes
    localparam logic [2:0] PSC_FD1 = 3'h0;
    localparam logic [2:0] PSC_FD2 = 3'h1;
    localparam logic [2:0] PSC_FD3 = 3'h2;
    localparam logic [2:0] PSC_DM2 = 3'h3;
    localparam logic [2:0] PSC_DM4 = 3'h4;
    localparam logic [2:0] PSC_DM8 = 3'h5;
    localparam logic [2:0] PSC_DM16 = 3'h6;
    localparam logic [2:0] PSC_DM32 = 3'h7;

    // Reference loss timeout in clock cycles
    localparam int REF_LOSS_CYCLES = 1024;

    typedef enum logic [1:0] {
        REF_OFF, REF_DIFF, REF_SINGLE, REF_CRYSTAL
    } prfsd_refmode_t;

    typedef struct packed {
        logic diffOn;
        logic priOn;
        logic secOn;
        logic xtalOn;
        logic seLowBias;
    } prfsd_pwr_t;

    typedef struct packed {
        logic [12:0] mainCount;
        logic [5:0] swallowCount;
    } prfsd_ncount_t;

    typedef struct packed {
        logic [7:0] refDivLo;
        logic [7:0] refDivHi;
        logic [7:0] pscCtrl;
        logic [7:0] offsetCfg;
        logic [7:0] syncCtrl;
        logic [7:0] monSel;
        logic [7:0] refCtrl;
        logic [7:0] rdData;
        logic prevPos;
        logic prevNeg;
        logic prevFb;
        logic [15:0] missPri;
        logic [15:0] missSec;
        logic useSec;
        logic degWait;
        logic [13:0] rCnt;
        logic [5:0] pscCnt;
        logic [5:0] aCnt;
        logic [12:0] bCnt;
        logic refDivOut;
        logic fbDivOut;
        logic monitorPin;
        logic statusPin;
        prfsd_pwr_t pwr;
        prfsd_refmode_t mode;
    } prfsd_state_t;

endpackage

// ===== design/prfsd_ref_switch.sv
module prfsd_ref_switch #(
    parameter int RefLossCycles = prfsd_pkg::REF_LOSS_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    // Register port from the serial control logic
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Device-level controls
    input wire logic pllPowerDown,
    input wire prfsd_pkg::prfsd_ncount_t nCounts,
    input wire logic refSelPin,
    input wire logic syncPinN,
    // Reference pin pair and feedback clock
    input wire logic refPinPos,
    input wire logic refPinNeg,
    input wire logic feedbackIn,
    // Phase detector side
    output logic refDivOut,
    output logic fbDivOut,
    // Status and power outputs
    output logic monitorPin,
    output logic statusPin,
    output logic usingSecondary,
    output prfsd_pkg::prfsd_pwr_t power,
    output prfsd_pkg::prfsd_refmode_t refMode
);

    prfsd_pkg::prfsd_state_t s_q;
    prfsd_pkg::prfsd_state_t s_d;

    // Base prescaler ratio for each mode code
    function automatic logic [5:0] pscBase(input logic [2:0] m);
        case (m)
            prfsd_pkg::PSC_FD1: pscBase = 6'h01;
            prfsd_pkg::PSC_FD2: pscBase = 6'h02;
            prfsd_pkg::PSC_FD3: pscBase = 6'h03;
            prfsd_pkg::PSC_DM2: pscBase = 6'h02;
            prfsd_pkg::PSC_DM4: pscBase = 6'h04;
            prfsd_pkg::PSC_DM8: pscBase = 6'h08;
            prfsd_pkg::PSC_DM16: pscBase = 6'h10;
            default: pscBase = 6'h20;
        endcase
    endfunction

    // Saturating missing-edge counter
    function automatic logic [15:0] missNext(
        input logic edgeSeen,
        input logic [15:0] cnt
    );
        if (edgeSeen) begin
            missNext = 16'h0000;
        end else if (cnt != 16'hffff) begin
            missNext = cnt + 16'h0001;
        end else begin
            missNext = cnt;
        end
    endfunction

    logic diffSel;
    logic xtalSel;
    logic priBad;
    logic secBad;
    logic autoCmd;
    logic wantSec;
    logic ePos;
    logic eNeg;
    logic eFb;
    logic newEdge;
    logic refEdge;
    logic syncLow;
    logic holdR;
    logic holdAB;
    logic dualMode;
    logic bypassB;
    logic [5:0] pBase;
    logic [6:0] modulus;
    logic [5:0] aLoad;
    logic [13:0] rRatio;
    logic [1:0] syncMode;

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.refDivOut = 1'b0;
        s_d.fbDivOut = 1'b0;

        // Register writes
        if (regWrEn) begin
            case (regAddr)
                prfsd_pkg::ADDR_REF_DIV_LO: s_d.refDivLo = regWrData;
                prfsd_pkg::ADDR_REF_DIV_HI: s_d.refDivHi = regWrData;
                prfsd_pkg::ADDR_PSC_CTRL: s_d.pscCtrl = regWrData;
                prfsd_pkg::ADDR_OFFSET_CFG: s_d.offsetCfg = regWrData;
                prfsd_pkg::ADDR_SYNC_CTRL: s_d.syncCtrl = regWrData;
                prfsd_pkg::ADDR_MON_SEL: s_d.monSel = regWrData;
                prfsd_pkg::ADDR_REF_CTRL: s_d.refCtrl = regWrData;
                default: ;
            endcase
        end

        // Read data registered; unmapped offsets read zero
        case (regAddr)
            prfsd_pkg::ADDR_REF_DIV_LO: s_d.rdData = s_q.refDivLo;
            prfsd_pkg::ADDR_REF_DIV_HI: s_d.rdData = s_q.refDivHi;
            prfsd_pkg::ADDR_PSC_CTRL: s_d.rdData = s_q.pscCtrl;
            prfsd_pkg::ADDR_OFFSET_CFG: s_d.rdData = s_q.offsetCfg;
            prfsd_pkg::ADDR_SYNC_CTRL: s_d.rdData = s_q.syncCtrl;
            prfsd_pkg::ADDR_MON_SEL: s_d.rdData = s_q.monSel;
            prfsd_pkg::ADDR_REF_CTRL: s_d.rdData = s_q.refCtrl;
            default: s_d.rdData = 8'h00;
        endcase

        // Input type and receiver power
        xtalSel = s_q.offsetCfg[prfsd_pkg::OFS_XTAL_EN];
        diffSel = s_q.refCtrl[prfsd_pkg::REF_DIFF_EN] | xtalSel;
        s_d.pwr.diffOn = diffSel & ~pllPowerDown;
        s_d.pwr.priOn = s_q.refCtrl[prfsd_pkg::REF_PRI_EN] & ~diffSel
            & ~pllPowerDown;
        s_d.pwr.secOn = s_q.refCtrl[prfsd_pkg::REF_SEC_EN] & ~diffSel
            & ~pllPowerDown;
        s_d.pwr.xtalOn = xtalSel;
        s_d.pwr.seLowBias = s_q.offsetCfg[prfsd_pkg::OFS_SE_LOW_BIAS];
        // Nothing is on until software enables a type
        if (xtalSel) begin
            s_d.mode = prfsd_pkg::REF_CRYSTAL;
        end else if (diffSel) begin
            s_d.mode = prfsd_pkg::REF_DIFF;
        end else if (s_q.refCtrl[prfsd_pkg::REF_PRI_EN]
                || s_q.refCtrl[prfsd_pkg::REF_SEC_EN]) begin
            s_d.mode = prfsd_pkg::REF_SINGLE;
        end else begin
            s_d.mode = prfsd_pkg::REF_OFF;
        end

        // Reference edges seen only through powered receivers; feedback edges ungated
        ePos = refPinPos & ~s_q.prevPos & (s_q.pwr.priOn | s_q.pwr.diffOn);
        eNeg = refPinNeg & ~s_q.prevNeg & s_q.pwr.secOn;
        eFb = feedbackIn & ~s_q.prevFb;
        s_d.prevPos = refPinPos;
        s_d.prevNeg = refPinNeg;
        s_d.prevFb = feedbackIn;

        // Reference presence monitor
        s_d.missPri = missNext(ePos, s_q.missPri);
        s_d.missSec = missNext(eNeg, s_q.missSec);
        priBad = ~s_q.pwr.priOn || (s_q.missPri >= 16'(RefLossCycles));
        secBad = ~s_q.pwr.secOn || (s_q.missSec >= 16'(RefLossCycles));

        // Monitor pin source
        case (s_q.monSel)
            prfsd_pkg::MON_PRI_BAD: s_d.monitorPin = priBad;
            prfsd_pkg::MON_SEC_BAD: s_d.monitorPin = secBad;
            default: s_d.monitorPin = 1'b0;
        endcase
        // Status pin flags loss of the preferred reference
        s_d.statusPin = s_q.refCtrl[prfsd_pkg::REF_PREFER_SEC]
            ? secBad : priBad;

        // Switchover decision; automatic mode reverts on recovery
        autoCmd = s_q.offsetCfg[prfsd_pkg::OFS_USE_STATUS]
            ? s_q.statusPin : s_q.monitorPin;
        if (s_q.refCtrl[prfsd_pkg::REF_AUTO_EN]) begin
            wantSec = s_q.refCtrl[prfsd_pkg::REF_PREFER_SEC]
                ^ autoCmd;
        end else if (s_q.refCtrl[prfsd_pkg::REF_PIN_SEL_EN]) begin
            wantSec = refSelPin;
        end else begin
            wantSec = s_q.refCtrl[prfsd_pkg::REF_MAN_SEC];
        end
        if (diffSel) begin
            wantSec = 1'b0;
        end
        s_d.useSec = wantSec;

        // Deglitch: after a change, wait for the new reference edge.
        // Without that edge the path stays blocked, so software must
        // switch only to a running reference or disable this.
        newEdge = s_q.useSec ? eNeg : ePos;
        if (wantSec != s_q.useSec
                && !s_q.refCtrl[prfsd_pkg::REF_DEGLITCH_OFF]) begin
            s_d.degWait = 1'b1;
        end else if (newEdge
                || s_q.refCtrl[prfsd_pkg::REF_DEGLITCH_OFF]) begin
            s_d.degWait = 1'b0;
        end
        refEdge = newEdge & ~s_q.degWait;

        // Divider reset sources
        syncMode = s_q.syncCtrl[prfsd_pkg::SYNC_MODE_LSB +: 2];
        syncLow = ~syncPinN && (syncMode != prfsd_pkg::SYNC_OFF);
        holdR = s_q.pscCtrl[prfsd_pkg::PSC_RST_R]
            || s_q.pscCtrl[prfsd_pkg::PSC_RST_SHARED]
            || (syncLow && syncMode != prfsd_pkg::SYNC_AB);
        holdAB = s_q.pscCtrl[prfsd_pkg::PSC_RST_AB]
            || s_q.pscCtrl[prfsd_pkg::PSC_RST_SHARED]
            || (syncLow && syncMode != prfsd_pkg::SYNC_R);

        // Reference divider; settings 0 and 1 both divide by one
        rRatio = {s_q.refDivHi[prfsd_pkg::REF_DIV_HI_BITS-1:0],
            s_q.refDivLo};
        if (holdR) begin
            s_d.rCnt = 14'h0000;
        end else if (refEdge) begin
            if (s_q.rCnt + 14'h0001 >= rRatio) begin
                s_d.rCnt = 14'h0000;
                s_d.refDivOut = 1'b1;
            end else begin
                s_d.rCnt = s_q.rCnt + 14'h0001;
            end
        end

        // Feedback divider: A prescaler periods of P+1, rest of P
        pBase = pscBase(s_q.pscCtrl[prfsd_pkg::PSC_MODE_LSB +: 3]);
        dualMode = s_q.pscCtrl[prfsd_pkg::PSC_MODE_LSB +: 3]
            >= prfsd_pkg::PSC_DM2;
        bypassB = s_q.pscCtrl[prfsd_pkg::PSC_B_BYPASS];
        // Zero swallow count means zero; unused when fixed or bypassed
        aLoad = (dualMode && !bypassB)
            ? nCounts.swallowCount : 6'h00;
        modulus = (dualMode && s_q.aCnt != 6'h00)
            ? {1'b0, pBase} + 7'h01 : {1'b0, pBase};
        if (holdAB) begin
            s_d.pscCnt = 6'h00;
            s_d.bCnt = 13'h0000;
            s_d.aCnt = aLoad;
        end else if (eFb) begin
            if ({1'b0, s_q.pscCnt} + 7'h01 >= modulus) begin
                s_d.pscCnt = 6'h00;
                if (s_q.aCnt != 6'h00) begin
                    s_d.aCnt = s_q.aCnt - 6'h01;
                end
                // Bypassed main counter ends each prescaler period
                if (bypassB || s_q.bCnt + 13'h0001
                        >= nCounts.mainCount) begin
                    s_d.bCnt = 13'h0000;
                    s_d.aCnt = aLoad;
                    s_d.fbDivOut = 1'b1;
                end else begin
                    s_d.bCnt = s_q.bCnt + 13'h0001;
                end
            end else begin
                s_d.pscCnt = s_q.pscCnt + 6'h01;
            end
        end
    end

    // Single state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.refDivLo <= prfsd_pkg::REG_RESET;
            s_q.refDivHi <= prfsd_pkg::REG_RESET;
            s_q.pscCtrl <= prfsd_pkg::REG_RESET;
            s_q.offsetCfg <= prfsd_pkg::REG_RESET;
            s_q.syncCtrl <= prfsd_pkg::REG_RESET;
            s_q.monSel <= prfsd_pkg::REG_RESET;
            s_q.refCtrl <= prfsd_pkg::REG_RESET;
            s_q.mode <= prfsd_pkg::REF_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign regRdData = s_q.rdData;
    assign refDivOut = s_q.refDivOut;
    assign fbDivOut = s_q.fbDivOut;
    assign monitorPin = s_q.monitorPin;
    assign statusPin = s_q.statusPin;
    assign usingSecondary = s_q.useSec;
    assign power = s_q.pwr;
    assign refMode = s_q.mode;

endmodule

// ===== test/prfsd_ref_source.sv
module prfsd_ref_source (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Edge budget per line: primary, secondary, feedback
    input wire logic [15:0] stopAt [3],
    // Reference and feedback lines with their rising edge counts
    output logic [2:0] line,
    output logic [15:0] cnt [3]
);
    // Toggle each line until its count meets its stop value, then park low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            line <= '0;
            cnt <= '{default: '0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (line[i] || cnt[i] != stopAt[i]) begin
                    line[i] <= !line[i];
                    cnt[i] <= cnt[i] + 16'(!line[i]);
                end
            end
        end
    end
endmodule

// ===== test/prfsd_ref_switch_asserts.sv
module prfsd_ref_switch_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // Controls and outputs
    input wire logic pllPowerDown,
    input wire logic syncPinN,
    input wire logic refDivOut,
    input wire logic fbDivOut,
    input wire logic monitorPin,
    input wire logic usingSecondary,
    input wire prfsd_pkg::prfsd_pwr_t power,
    input wire prfsd_pkg::prfsd_refmode_t refMode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic mapped_q, refSet_q, rHeld_q, abHeld_q, syncAll_q, monOff_q;
    // Shadow of the few register bits the properties depend on
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {mapped_q, refSet_q, rHeld_q, abHeld_q, syncAll_q} <= '0;
            monOff_q <= 1'b1;
        end else begin
            mapped_q <= regAddr inside {8'h11, 8'h12, 8'h16, 8'h18, 8'h19,
                8'h1b, 8'h1c};
            if (regWrEn && regAddr == 8'h1c) refSet_q <= 1'b1;
            if (regWrEn && regAddr == 8'h16) begin
                rHeld_q <= regWrData[6] | regWrData[4];
                abHeld_q <= regWrData[5] | regWrData[4];
            end
            if (regWrEn && regAddr == 8'h19) begin
                syncAll_q <= regWrData[7:6] == 2'h1;
            end
            if (regWrEn && regAddr == 8'h1b) monOff_q <= regWrData < 8'hf7;
        end
    end
    // Register port behaviour
    read_back_a: assert property (
        regWrEn && regAddr == 8'h1c ##1 $stable(regAddr)
        |=> regRdData == $past(regWrData, 2))
        else $error("Reference control read back wrong");
    read_unmapped_a: assert property (!mapped_q |-> regRdData == 8'h00)
        else $error("Unmapped offset read not zero");
    // Receiver power, mode and crystal amplifier
    off_until_enabled_a: assert property (!refSet_q |->
        !power.diffOn && !power.priOn && !power.secOn && !power.xtalOn)
        else $error("Receiver on before being enabled");
    diff_excl_a: assert property (
        power.diffOn |-> !power.priOn && !power.secOn)
        else $error("Single-ended buffer on in differential mode");
    pll_down_a: assert property (pllPowerDown [*3] |->
        !power.diffOn && !power.priOn && !power.secOn)
        else $error("Receiver on while PLL is down");
    xtal_mode_a: assert property (
        power.xtalOn |-> refMode == prfsd_pkg::REF_CRYSTAL)
        else $error("Crystal amplifier on outside crystal mode");
    // Divider holds give no output edges; monitor pin quiet with no source
    r_hold_a: assert property (rHeld_q [*6] |-> !refDivOut)
        else $error("Reference divider pulsed while held");
    ab_hold_a: assert property (abHeld_q [*6] |-> !fbDivOut)
        else $error("Feedback divider pulsed while held");
    sync_hold_a: assert property (
        (syncAll_q && !syncPinN) [*6] |-> !refDivOut && !fbDivOut)
        else $error("Divider pulsed during pin sync");
    mon_quiet_a: assert property (monOff_q [*3] |-> !monitorPin)
        else $error("Monitor pin high with no source chosen");
    // Main scenarios reached
    cover property (refDivOut && fbDivOut);
    cover property ($rose(monitorPin));
    cover property ($fell(usingSecondary));
endmodule

// ===== test/prfsd_ref_switch_tb_top.sv
module prfsd_ref_switch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] ctl; logic [7:0] ofs; logic down; logic [4:0] pwr;
        logic [1:0] mode;
    } prfsd_cfg_t;
    typedef struct packed {
        logic [13:0] r; logic [7:0] psc; logic [12:0] b; logic [5:0] a;
        logic [15:0] nr; logic [15:0] nf; logic [7:0] er; logic [7:0] ef;
    } prfsd_div_t;
    localparam int LossCycles = 32;
    logic clock = 0, reset = 1, regWrEn = 0, pllPowerDown = 0;
    logic refSelPin = 0, syncPinN = 0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic refDivOut, fbDivOut, monitorPin, statusPin, usingSecondary;
    prfsd_pkg::prfsd_ncount_t nCounts = '0;
    prfsd_pkg::prfsd_pwr_t power;
    prfsd_pkg::prfsd_refmode_t refMode;
    logic [2:0] line;
    logic [15:0] stopAt [3] = '{default: '0};
    logic [15:0] cnt [3];
    int error_cnt = 0, n_checks = 0, rP = 0, fP = 0;
    prfsd_cfg_t cfgRows [8] = '{
        '{8'h01, 8'h00, 0, 5'b10000, 1}, '{8'h06, 8'h00, 0, 5'b01100, 2},
        '{8'h02, 8'h80, 0, 5'b01001, 2}, '{8'h04, 8'h00, 0, 5'b00100, 2},
        '{8'h07, 8'h00, 0, 5'b10000, 1}, '{8'h01, 8'h01, 0, 5'b10010, 3},
        '{8'h06, 8'h00, 1, 5'b00000, 0}, '{8'h00, 8'h00, 0, 5'b00000, 0}};
    prfsd_div_t divRows [10] = '{
        '{1, 8'h08, 0, 0, 4, 5, 4, 5}, '{0, 8'h09, 0, 0, 3, 6, 3, 3},
        '{3, 8'h0a, 0, 0, 9, 6, 3, 2}, '{2, 8'h03, 3, 1, 4, 14, 2, 2},
        '{5, 8'h01, 3, 2, 10, 12, 2, 2}, '{1, 8'h04, 3, 0, 2, 24, 2, 2},
        '{1, 8'h0d, 0, 0, 2, 16, 2, 2}, '{1, 8'h0e, 0, 0, 2, 32, 2, 2},
        '{1, 8'h0f, 0, 0, 1, 32, 1, 1}, '{16383, 8'h00, 3, 0, 16383, 3, 1, 1}};
    prfsd_ref_switch #(.RefLossCycles(LossCycles)) i_prfsd_ref_switch (
        .clock, .reset, .regAddr, .regWrEn, .regWrData, .regRdData,
        .pllPowerDown, .nCounts, .refSelPin, .syncPinN, .refPinPos(line[0]),
        .refPinNeg(line[1]), .feedbackIn(line[2]), .refDivOut, .fbDivOut,
        .monitorPin, .statusPin, .usingSecondary, .power, .refMode);
    prfsd_ref_source i_prfsd_ref_source (.clock, .reset, .stopAt, .line, .cnt);
    // Free-running 200 MHz clock
    initial forever #2.5 clock = !clock;
    // Count divider pulses; each stands one cycle
    always @(posedge clock) begin
        if (refDivOut === 1'b1) rP++;
        if (fbDivOut === 1'b1) fP++;
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clock);
    endtask
    // Write one byte, hold the offset and read it back
    task automatic wr(logic [7:0] a, logic [7:0] d, logic [7:0] e);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        cyc(1);
        regWrEn = 0;
        cyc(1);
        check("readback", regRdData, e);
    endtask
    // Let one line make n more rising edges and wait until it parks
    task automatic run(int ch, int n);
        int k;
        stopAt[ch] = 16'(cnt[ch] + n);
        for (k = 0; k < 4 * n + 8 && (cnt[ch] != stopAt[ch] || line[ch]); k++)
            cyc(1);
        if (k == 4 * n + 8) begin
            check("edge wait", 8'h00, 8'h01);
            print_verdict();
        end
    endtask
    // Program the prescaler, send edges, count both divider outputs
    task automatic burst(logic [7:0] psc, int nr, int nf, int er, int ef);
        wr(8'h16, psc, psc);
        cyc(2);
        rP = 0;
        fP = 0;
        run(0, nr);
        run(2, nf);
        cyc(6);
        check("refPulses", rP[7:0], 8'(er));
        check("fbPulses", fP[7:0], 8'(ef));
    endtask
    task automatic idle();
        check("power", 8'(power), 8'h00);
        check("refMode", 8'(refMode), 8'h00);
        check("regRdData", regRdData, 8'h00);
    endtask
    initial begin
        cyc(5);
        reset = 0;
        idle();
        wr(8'h13, 8'h5a, 8'h00);
        foreach (cfgRows[i]) begin
            wr(8'h18, cfgRows[i].ofs, cfgRows[i].ofs);
            wr(8'h1c, cfgRows[i].ctl, cfgRows[i].ctl);
            pllPowerDown = cfgRows[i].down;
            cyc(4);
            check("power", 8'(power),
                8'(cfgRows[i].pwr));
            if (!cfgRows[i].down) begin
                check("refMode", 8'(refMode),
                    8'(cfgRows[i].mode));
            end
        end
        pllPowerDown = 0;
        $display("Test receiver settings done");
        wr(8'h1c, 8'h02, 8'h02);
        // Sync pin held low throughout: its reset is off after reset
        foreach (divRows[i]) begin
            wr(8'h11, divRows[i].r[7:0], divRows[i].r[7:0]);
            wr(8'h12, {2'b00, divRows[i].r[13:8]}, {2'b00, divRows[i].r[13:8]});
            nCounts = {divRows[i].b, divRows[i].a};
            burst(divRows[i].psc | 8'h70, divRows[i].nr, divRows[i].nf,
                0, 0);
            burst(divRows[i].psc, divRows[i].nr, divRows[i].nf, divRows[i].er,
                divRows[i].ef);
        end
        $display("Test divider ratios done");
        wr(8'h11, 8'h01, 8'h01);
        wr(8'h12, 8'h00, 8'h00);
        burst(8'h18, 3, 3, 0, 0);
        burst(8'h48, 3, 3, 0, 3);
        burst(8'h28, 3, 3, 3, 0);
        foreach (divRows[i]) if (i < 3) begin
            wr(8'h19, 8'(i + 1) << 6, 8'(i + 1) << 6);
            burst(8'h08, 3, 3, i == 1 ? 3 : 0, i == 2 ? 3 : 0);
        end
        syncPinN = 1;
        burst(8'h08, 3, 3, 3, 3);
        $display("Test holds and sync done");
        wr(8'h1c, 8'h16, 8'h16);
        rP = 0;
        run(1, 3);
        cyc(6);
        check("refPulses", rP[7:0], 8'h02);
        check("usingSecondary", 8'(usingSecondary), 8'h01);
        wr(8'h1c, 8'h86, 8'h86);
        rP = 0;
        run(0, 3);
        cyc(6);
        check("refPulses", rP[7:0], 8'h03);
        wr(8'h1c, 8'h8e, 8'h8e);
        refSelPin = 1;
        cyc(4);
        check("usingSecondary", 8'(usingSecondary), 8'h01);
        refSelPin = 0;
        cyc(4);
        check("usingSecondary", 8'(usingSecondary), 8'h00);
        $display("Test manual switchover done");
        wr(8'h1b, 8'hf7, 8'hf7);
        wr(8'h1c, 8'h26, 8'h26);
        stopAt = '{16'(cnt[0] + 3000), 16'(cnt[1] + 3000), cnt[2]};
        cyc(20);
        check("monitorPin", 8'(monitorPin), 8'h00);
        stopAt[0] = cnt[0];
        cyc(LossCycles + 40);
        check("monitorPin", 8'(monitorPin), 8'h01);
        check("usingSecondary", 8'(usingSecondary), 8'h01);
        check("statusPin", 8'(statusPin), 8'h01);
        stopAt[0] = 16'(cnt[0] + 3000);
        cyc(40);
        check("monitorPin", 8'(monitorPin), 8'h00);
        check("usingSecondary", 8'(usingSecondary), 8'h00);
        wr(8'h1c, 8'h66, 8'h66);
        cyc(20);
        check("usingSecondary", 8'(usingSecondary), 8'h01);
        $display("Test automatic switchover done");
        stopAt = '{default: '0};
        reset = 1;
        cyc(2);
        reset = 0;
        idle();
        $display("Test second reset done");
        print_verdict();
    end
endmodule
bind prfsd_ref_switch prfsd_ref_switch_asserts i_prfsd_ref_switch_asserts (
    .clock, .reset, .regAddr, .regWrEn, .regWrData, .regRdData,
    .pllPowerDown, .syncPinN, .refDivOut, .fbDivOut, .monitorPin,
    .usingSecondary, .power, .refMode);
